// >>> offcore_response_filter.sv
// Summary of operation
// RULE1 - Code 0xB7, unit mask 0x01 on first counter, 0xBB/0x01 on fourth, select counting.
// RULE2 - First counter uses filter at 0x1A6, fourth counter uses filter at 0x1A7.
// RULE3 - Filter: request bits 15:0, supplier bits 30:16, snoop bits 37:31.
// RULE4 - Request bit 0: demand, L1 prefetch and page-walk data reads.
// RULE5 - Request bit 1: demand and L1 prefetch ownership reads.
// RULE6 - Request bit 2: demand and L1 prefetch instruction reads.
// RULE7 - Request bit 3: modified-to-exclusive writebacks.
// RULE8 - Request bits 4..6: L2 prefetch data, ownership and code reads.
// RULE9 - Request bits 7..9: L2 prefetches into L3 for loads, ownership, fetches.
// RULE10 - Bit 10 locked requests, bit 11 streaming stores.
// RULE11 - Request bit 15: any other interface request, including I/O.
// RULE12 - Response bit 16 accepts every response.
// RULE13 - Bit 17 no supplier info, bit 22 local memory controller.
// RULE14 - Bits 18..21: L3 lookup found line modified, exclusive, shared, forward.
// RULE15 - Bits 31..37: snoop none, unneeded, miss, hit, forward, modified, non-memory.
// RULE16 - Software sets at least one non-reserved request bit for a valid filter.
// RULE17 - Invalid request or response pattern makes the counter read zero.
// RULE18 - Several request and response bits may be set together.
// RULE19 - Response valid only with catch-all, or supplier and snoop bits both set.
// RULE20 - Catch-all set means supplier and snoop bits are ignored.
// RULE21 - A matching transaction increments the enabled counter exactly once.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`include "offcore_filter_cfg.svh"
`default_nettype none

module offcore_response_filter #(
	parameter int CNT_W = 32
) (
	input  wire logic        clk,           // System clock, 250 MHz
	input  wire logic        reset,         // Synchronous, active high
	input  wire logic [11:0] s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output var  logic        s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output var  logic        s_axi_wready,  // Write data ready
	output var  logic [1:0]  s_axi_bresp,   // Write response
	output var  logic        s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	input  wire logic [11:0] s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output var  logic        s_axi_arready, // Read address ready
	output var  logic [31:0] s_axi_rdata,   // Read data
	output var  logic [1:0]  s_axi_rresp,   // Read response
	output var  logic        s_axi_rvalid,  // Read data valid
	input  wire logic        s_axi_rready,  // Read data ready
	input  wire logic        txn_valid,     // One completed off-core transaction
	input  wire logic [3:0]  txn_class,     // Request class, index of request bit
	input  wire logic [5:0]  txn_supplier,  // Supplier, one-hot, bits 17..22
	input  wire logic [6:0]  txn_snoop      // Snoop outcome, one-hot, bits 31..37
);

	// Counter width must fit the 32-bit register word
	if (CNT_W < 1 || CNT_W > 32) begin : g_cnt_w_check
		$error("CNT_W must lie between 1 and 32");
	end

	// ------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------

	// Request pattern valid: some non-reserved request bit is set
	function automatic logic req_ok(input logic [`OCR_FILT_W-1:0] f);
		req_ok = |f[`OCR_REQ_MSB:`OCR_REQ_LSB]; // RULE16
	endfunction : req_ok

	// Response pattern valid: catch-all, or supplier and snoop both chosen
	function automatic logic rsp_ok(input logic [`OCR_FILT_W-1:0] f);
		rsp_ok = f[`OCR_ANY_BIT] | ((|f[`OCR_SUP_MSB:`OCR_SUP_LSB])
			& (|f[`OCR_SNP_MSB:`OCR_SNP_LSB])); // RULE19
	endfunction : rsp_ok

	// Transaction match against one filter; several bits may be set at once
	function automatic logic filt_hit(input logic [`OCR_FILT_W-1:0] f,
		input logic [3:0] cls, input logic [5:0] sup, input logic [6:0] snp);
		logic req_m;
		logic rsp_m;
		req_m = f[cls]; // RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11
		rsp_m = f[`OCR_ANY_BIT] // RULE12 RULE20
			| ((|(sup & f[`OCR_SUP_MSB:`OCR_SUP_LSB])) // RULE13 RULE14
			& (|(snp & f[`OCR_SNP_MSB:`OCR_SNP_LSB]))); // RULE15
		filt_hit = req_m & rsp_m & req_ok(f) & rsp_ok(f); // RULE18 RULE17
	endfunction : filt_hit

	// Byte-lane merge of a 32-bit write
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = dat[b*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [`OCR_FILT_W-1:0] filt_q [2];   // offcore_filter_zero / _one
	logic [31:0]            evsel_q [2];  // Event selects of the two counters
	logic [CNT_W-1:0]       cnt_q [2];    // first_counter, fourth_counter
	logic                   aw_got_q;
	logic                   w_got_q;
	logic [11:0]            aw_addr_q;
	logic [31:0]            w_data_q;
	logic [3:0]             w_strb_q;
	logic                   wr_fire;
	logic [1:0]             sel_ok;
	logic [1:0]             hit;
	logic [1:0]             cnt_wr;
	logic [63:0]            f64 [2];

	// Widened filter views for the bus
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			f64[i] = {26'h000_0000, filt_q[i]};
		end
	end

	// Counter selection: only the dedicated code and unit mask count
	always_comb begin
		sel_ok[0] = evsel_q[0][`OCR_EV_EN_BIT]
			&& evsel_q[0][`OCR_EV_CODE_MSB:0] == `OCR_CODE_FIRST
			&& evsel_q[0][`OCR_EV_MASK_MSB:`OCR_EV_MASK_LSB] == `OCR_UNIT_MASK_SEL; // RULE1
		sel_ok[1] = evsel_q[1][`OCR_EV_EN_BIT]
			&& evsel_q[1][`OCR_EV_CODE_MSB:0] == `OCR_CODE_FOURTH
			&& evsel_q[1][`OCR_EV_MASK_MSB:`OCR_EV_MASK_LSB] == `OCR_UNIT_MASK_SEL; // RULE1
	end

	// Each counter looks only at its own filter
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			hit[i] = txn_valid && sel_ok[i]
				&& filt_hit(filt_q[i], txn_class, txn_supplier, txn_snoop); // RULE2 RULE21
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------

	// Address and data are taken independently, in either order
	always_ff @(posedge clk) begin
		if (reset) begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_got_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q  <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_got_q <= 1'b0;
			end
		end
	end

	assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

	// Ready drops once a beat is held, so nothing is overwritten
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !(aw_got_q || (s_axi_awvalid && s_axi_awready)) || wr_fire;
			s_axi_wready  <= !(w_got_q || (s_axi_wvalid && s_axi_wready)) || wr_fire;
		end
	end

	// Write response follows both beats; unmapped address answers SLVERR
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= offcore_filter_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr_q)
				`OCR_ADDR_FILT0_LO, `OCR_ADDR_FILT1_LO, `OCR_ADDR_FILT0_HI,
				`OCR_ADDR_FILT1_HI, `OCR_ADDR_EVSEL0, `OCR_ADDR_EVSEL3,
				`OCR_ADDR_CNT0, `OCR_ADDR_CNT3: begin
					s_axi_bresp <= offcore_filter_pkg::RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= offcore_filter_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Filter registers; reserved bits are never stored
	always_ff @(posedge clk) begin
		if (reset) begin
			filt_q[0] <= `OCR_FILT_RESET;
			filt_q[1] <= `OCR_FILT_RESET;
		end else if (wr_fire) begin
			case (aw_addr_q)
				`OCR_ADDR_FILT0_LO: filt_q[0] <= `OCR_FILT_MASK & {filt_q[0][37:32],
					merge(f64[0][31:0], w_data_q, w_strb_q)}; // RULE3
				`OCR_ADDR_FILT1_LO: filt_q[1] <= `OCR_FILT_MASK & {filt_q[1][37:32],
					merge(f64[1][31:0], w_data_q, w_strb_q)}; // RULE3
				`OCR_ADDR_FILT0_HI: filt_q[0] <= `OCR_FILT_MASK & {`OCR_HI_W'(merge(
					f64[0][63:32], w_data_q, w_strb_q)), filt_q[0][31:0]}; // RULE3
				`OCR_ADDR_FILT1_HI: filt_q[1] <= `OCR_FILT_MASK & {`OCR_HI_W'(merge(
					f64[1][63:32], w_data_q, w_strb_q)), filt_q[1][31:0]}; // RULE3
				default: begin
				end
			endcase
		end
	end

	// Event selects
	always_ff @(posedge clk) begin
		if (reset) begin
			evsel_q[0] <= `OCR_EVSEL_RESET;
			evsel_q[1] <= `OCR_EVSEL_RESET;
		end else if (wr_fire && aw_addr_q == `OCR_ADDR_EVSEL0) begin
			evsel_q[0] <= `OCR_EVSEL_MASK & merge(evsel_q[0], w_data_q, w_strb_q);
		end else if (wr_fire && aw_addr_q == `OCR_ADDR_EVSEL3) begin
			evsel_q[1] <= `OCR_EVSEL_MASK & merge(evsel_q[1], w_data_q, w_strb_q);
		end
	end

	assign cnt_wr[0] = wr_fire && aw_addr_q == `OCR_ADDR_CNT0;
	assign cnt_wr[1] = wr_fire && aw_addr_q == `OCR_ADDR_CNT3;

	// Counters; a hit in the cycle of a write still counts on the new value
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q[0] <= '0;
			cnt_q[1] <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (cnt_wr[i]) begin
					cnt_q[i] <= CNT_W'(merge(32'(cnt_q[i]), w_data_q, w_strb_q))
						+ CNT_W'(hit[i]);
				end else if (hit[i]) begin
					cnt_q[i] <= cnt_q[i] + CNT_W'(1); // RULE21
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------

	// One read in flight; data is latched at the address handshake
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= offcore_filter_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= offcore_filter_pkg::RESP_OKAY;
			case (s_axi_araddr)
				`OCR_ADDR_FILT0_LO: s_axi_rdata <= f64[0][31:0];
				`OCR_ADDR_FILT1_LO: s_axi_rdata <= f64[1][31:0];
				`OCR_ADDR_FILT0_HI: s_axi_rdata <= f64[0][63:32];
				`OCR_ADDR_FILT1_HI: s_axi_rdata <= f64[1][63:32];
				`OCR_ADDR_EVSEL0:   s_axi_rdata <= evsel_q[0];
				`OCR_ADDR_EVSEL3:   s_axi_rdata <= evsel_q[1];
				// Invalid pattern reads as zero count
				`OCR_ADDR_CNT0: s_axi_rdata <= (req_ok(filt_q[0]) && rsp_ok(filt_q[0]))
					? 32'(cnt_q[0]) : 32'h0000_0000; // RULE17
				`OCR_ADDR_CNT3: s_axi_rdata <= (req_ok(filt_q[1]) && rsp_ok(filt_q[1]))
					? 32'(cnt_q[1]) : 32'h0000_0000; // RULE17
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= offcore_filter_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_first_counts;
		hit[0] && !cnt_wr[0] |=> cnt_q[0] == $past(cnt_q[0]) + CNT_W'(1);
	endproperty
	a_first_counts: assert property (p_first_counts) // RULE21
		else $error("first counter missed a matching transaction");

	property p_code_gate;
		!sel_ok[1] && !cnt_wr[1] |=> $stable(cnt_q[1]);
	endproperty
	a_code_gate: assert property (p_code_gate) // RULE1
		else $error("fourth counter moved without its event code");

	property p_own_filter;
		txn_valid && sel_ok[1] && !filt_q[1][txn_class] && !cnt_wr[1] |=> $stable(cnt_q[1]);
	endproperty
	a_own_filter: assert property (p_own_filter) // RULE2
		else $error("fourth counter counted a class its filter excludes");

	property p_invalid_zero;
		!rsp_ok(filt_q[0]) && !cnt_wr[0] |=> $stable(cnt_q[0]);
	endproperty
	a_invalid_zero: assert property (p_invalid_zero) // RULE17
		else $error("counter moved with invalid response pattern");

	property p_read_zero;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `OCR_ADDR_CNT0
			&& !req_ok(filt_q[0]) |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
	endproperty
	a_read_zero: assert property (p_read_zero) // RULE17
		else $error("counter read nonzero without request pattern");

	property p_any_ignores;
		txn_valid && sel_ok[0] && filt_q[0][`OCR_ANY_BIT] && filt_q[0][txn_class]
			&& !cnt_wr[0] |=> cnt_q[0] != $past(cnt_q[0]);
	endproperty
	a_any_ignores: assert property (p_any_ignores) // RULE20
		else $error("catch-all response did not count");

	property p_write_answer;
		aw_got_q && w_got_q && !s_axi_bvalid |=> s_axi_bvalid ##0 !aw_got_q;
	endproperty
	a_write_answer: assert property (p_write_answer) // AXI4-Lite write timing, decided locally
		else $error("write response not given one cycle after both beats");

	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_read_answer: assert property (p_read_answer) // AXI4-Lite read timing, decided locally
		else $error("read data not given one cycle after the address");

endmodule : offcore_response_filter

`default_nettype wire

// >>> offcore_filter_cfg.svh
`ifndef OFFCORE_FILTER_CFG_SVH
`define OFFCORE_FILTER_CFG_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define OCR_IDX_FILT0      12'h1A6
`define OCR_IDX_FILT1      12'h1A7
`define OCR_ADDR_FILT0_LO  12'h698
`define OCR_ADDR_FILT1_LO  12'h69C
`define OCR_ADDR_FILT0_HI  12'h700
`define OCR_ADDR_FILT1_HI  12'h704
`define OCR_ADDR_EVSEL0    12'h710
`define OCR_ADDR_EVSEL3    12'h714
`define OCR_ADDR_CNT0      12'h718
`define OCR_ADDR_CNT3      12'h71C

// ----------------------------------------------------------------------
// Filter field layout
// ----------------------------------------------------------------------
`define OCR_FILT_W         38
`define OCR_FILT_MASK      38'h3F_807F_8FFF
`define OCR_FILT_RESET     38'h00_0000_0000
`define OCR_REQ_LSB        0
`define OCR_REQ_MSB        15
`define OCR_ANY_BIT        16
`define OCR_SUP_LSB        17
`define OCR_SUP_MSB        22
`define OCR_SNP_LSB        31
`define OCR_SNP_MSB        37
`define OCR_HI_W           6

// ----------------------------------------------------------------------
// Event select layout
// ----------------------------------------------------------------------
`define OCR_EV_CODE_MSB    7
`define OCR_EV_MASK_LSB    8
`define OCR_EV_MASK_MSB    15
`define OCR_EV_EN_BIT      22
`define OCR_EVSEL_MASK     32'h0040_FFFF
`define OCR_EVSEL_RESET    32'h0000_0000
`define OCR_CODE_FIRST     8'hB7
`define OCR_CODE_FOURTH    8'hBB
`define OCR_UNIT_MASK_SEL  8'h01

`endif

// >>> offcore_filter_pkg.sv
`default_nettype none

package offcore_filter_pkg;

	// AXI response codes used by the slave
	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_t;

	// Counter slots: first_counter and fourth_counter
	typedef enum logic {
		SLOT_FIRST  = 1'b0,
		SLOT_FOURTH = 1'b1
	} slot_t;

endpackage : offcore_filter_pkg

`default_nettype wire

// >>> txn_source_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----
// Transaction source standing in for the request path
// ----
module txn_source_model (
	input  wire logic       clk,          // System clock
	input  wire logic       reset,        // Sync, active high
	input  wire logic       go,           // Issue a transaction in the next cycle
	input  wire logic [3:0] cls,          // Request class to issue
	input  wire logic [5:0] sup,          // One-hot supplier
	input  wire logic [6:0] snp,          // One-hot snoop outcome
	output logic            txn_valid,    // Transaction pulse
	output logic [3:0]      txn_class,    // Request class index
	output logic [5:0]      txn_supplier, // Supplier lines
	output logic [6:0]      txn_snoop     // Snoop lines
);

	// One transaction per cycle; idle payload toggles so a stale value never matches by luck
	always_ff @(posedge clk) begin
		if (reset) begin
			txn_valid <= 1'b0;
			txn_class <= 4'h0;
			txn_supplier <= 6'h00;
			txn_snoop <= 7'h00;
		end else if (go) begin
			txn_valid <= 1'b1;
			txn_class <= cls;
			txn_supplier <= sup;
			txn_snoop <= snp;
		end else begin
			txn_valid <= 1'b0;
			txn_class <= ~txn_class;
			txn_supplier <= ~txn_supplier;
			txn_snoop <= ~txn_snoop;
		end
	end

endmodule : txn_source_model
`default_nettype wire

// >>> offcore_response_filter_test.sv
`timescale 1ns/10ps
`include "offcore_filter_cfg.svh"
`default_nettype none

module offcore_response_filter_test;

	// ----
	// Signals
	// ----
	localparam logic [31:0] B16 = 32'h0001_0000;
	localparam logic [31:0] B31 = 32'h8000_0000;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        txn_valid;
	logic [3:0]  txn_class;
	logic [5:0]  txn_supplier;
	logic [6:0]  txn_snoop;
	logic        go = 1'b0;
	logic [3:0]  cls = 4'h0;
	logic [5:0]  sup = 6'h00;
	logic [6:0]  snp = 7'h00;
	logic [1:0]  r;
	int          failures = 0;
	int          cmp_count = 0;
	logic [11:0] regs [8] = '{`OCR_ADDR_FILT0_LO, `OCR_ADDR_FILT1_LO, `OCR_ADDR_FILT0_HI,
		`OCR_ADDR_FILT1_HI, `OCR_ADDR_EVSEL0, `OCR_ADDR_EVSEL3, `OCR_ADDR_CNT0, `OCR_ADDR_CNT3};
	logic [31:0] evs [4] = '{32'h0040_01BB, 32'h0040_02B7, 32'h0000_01B7, 32'h0040_01B7};

	offcore_response_filter dut_u (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txn_valid, .txn_class, .txn_supplier,
		.txn_snoop);

	txn_source_model src_u (.clk, .reset, .go, .cls, .sup, .snp, .txn_valid, .txn_class,
		.txn_supplier, .txn_snoop);

	// Free-running clock, 4 ns period
	initial forever #2 clk = ~clk;

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	// Address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  rs;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(d, e);
		chk({30'h0, rs}, {30'h0, er});
	endtask : rchk

	// Two transactions back to back, so a double or lost count shows
	task automatic send(input logic [3:0] c, input logic [5:0] su, input logic [6:0] sn);
		@(posedge clk);
		go <= 1'b1;
		cls <= c;
		sup <= su;
		snp <= sn;
		repeat (2) @(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : send

	// Program one filter, clear its counter, send a pair and read the count
	task automatic trial(input logic f, input logic [31:0] lo, input logic [5:0] hi,
		input logic [3:0] c, input logic [5:0] su, input logic [6:0] sn, input logic [31:0] e);
		logic [1:0] rs;
		wr(f ? `OCR_ADDR_FILT1_LO : `OCR_ADDR_FILT0_LO, lo, rs);
		wr(f ? `OCR_ADDR_FILT1_HI : `OCR_ADDR_FILT0_HI, {26'h0, hi}, rs);
		wr(f ? `OCR_ADDR_CNT3 : `OCR_ADDR_CNT0, 32'h0, rs);
		send(c, su, sn);
		rchk(f ? `OCR_ADDR_CNT3 : `OCR_ADDR_CNT0, e, offcore_filter_pkg::RESP_OKAY);
	endtask : trial

	task automatic end_of_test();
		$display("comparisons=%0d failures=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	// ----
	// Watchdog and tests
	// ----
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		end_of_test();
	end

	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 8; i++) rchk(regs[i], 32'h0, offcore_filter_pkg::RESP_OKAY);
		rchk(12'h010, 32'h0, offcore_filter_pkg::RESP_SLVERR);
		wr(12'h010, 32'hFFFF_FFFF, r);
		chk({30'h0, r}, {30'h0, offcore_filter_pkg::RESP_SLVERR});
		// Reserved filter bits read back as zero
		wr(`OCR_ADDR_FILT0_LO, 32'hFFFF_FFFF, r);
		rchk(`OCR_ADDR_FILT0_LO, 32'h807F_8FFF, offcore_filter_pkg::RESP_OKAY);
		wr(`OCR_ADDR_FILT0_HI, 32'hFFFF_FFFF, r);
		rchk(`OCR_ADDR_FILT0_HI, 32'h0000_003F, offcore_filter_pkg::RESP_OKAY);
		// Only the right code, mask and enable count; last entry is correct
		wr(`OCR_ADDR_EVSEL3, 32'h0040_01B7, r);
		trial(1'b1, 32'h1 | B16, 6'h0, 4'h0, 6'h01, 7'h01, 32'h0);
		wr(`OCR_ADDR_EVSEL3, 32'h0040_01BB, r);
		for (int i = 0; i < 4; i++) begin
			wr(`OCR_ADDR_EVSEL0, evs[i], r);
			trial(1'b0, 32'h1 | B16, 6'h0, 4'h0, 6'h01, 7'h01, (i == 3) ? 32'h2 : 32'h0);
		end
		// Each non-reserved request bit against its own class and a neighbour
		for (int c = 0; c < 16; c++) begin
			if (c < 12 || c == 15) begin
				trial(1'b0, (32'h1 << c) | B16, 6'h0, c[3:0], 6'h01, 7'h01, 32'h2);
				trial(1'b0, (32'h1 << c) | B16, 6'h0, c[3:0] ^ 4'h1, 6'h01, 7'h01, 32'h0);
			end
		end
		// Supplier bits, snoop fixed at bit 31
		for (int s = 0; s < 6; s++) begin
			trial(1'b0, 32'h1 | (32'h1 << (17 + s)) | B31, 6'h0, 4'h0, 6'h1 << s, 7'h01, 32'h2);
			trial(1'b0, 32'h1 | (32'h1 << (17 + s)) | B31, 6'h0, 4'h0, 6'h1 << ((s + 1) % 6),
				7'h01, 32'h0);
		end
		// Snoop bits on the fourth counter, which reads the second filter
		for (int j = 0; j < 7; j++) begin
			trial(1'b1, 32'h2_0001 | ((j == 0) ? B31 : 32'h0), (j == 0) ? 6'h0 : 6'h1 << (j - 1),
				4'h0, 6'h01, 7'h1 << j, 32'h2);
			trial(1'b1, 32'h2_0001 | ((j == 0) ? B31 : 32'h0), (j == 0) ? 6'h0 : 6'h1 << (j - 1),
				4'h0, 6'h01, 7'h1 << ((j + 1) % 7), 32'h0);
		end
		// First filter does not reach the fourth counter; then catch-all, invalid response, reserved and paired request bits
		wr(`OCR_ADDR_CNT3, 32'h0, r);
		trial(1'b0, (32'h1 << 5) | B16, 6'h0, 4'h5, 6'h01, 7'h01, 32'h2);
		rchk(`OCR_ADDR_CNT3, 32'h0, offcore_filter_pkg::RESP_OKAY);
		trial(1'b0, 32'h1 | B16 | 32'h4_0000 | B31, 6'h0, 4'h0, 6'h20, 7'h40, 32'h2);
		trial(1'b0, 32'h1 | 32'h2_0000, 6'h0, 4'h0, 6'h01, 7'h01, 32'h0);
		trial(1'b0, 32'h7000 | B16, 6'h0, 4'hC, 6'h01, 7'h01, 32'h0);
		trial(1'b0, 32'h0808 | B16, 6'h0, 4'hB, 6'h01, 7'h01, 32'h2);
		// Counter load and event select read-back
		wr(`OCR_ADDR_CNT0, 32'h0000_1234, r);
		chk({30'h0, r}, {30'h0, offcore_filter_pkg::RESP_OKAY});
		rchk(`OCR_ADDR_CNT0, 32'h0000_1234, offcore_filter_pkg::RESP_OKAY);
		rchk(`OCR_ADDR_EVSEL0, 32'h0040_01B7, offcore_filter_pkg::RESP_OKAY);
		end_of_test();
	end

endmodule : offcore_response_filter_test
`default_nettype wire
